// ==== logic/bwbt_params.svh ====
`ifndef BWBT_PARAMS_SVH
`define BWBT_PARAMS_SVH

`define BWBT_OFF_LUT_BASE     8'h60
`define BWBT_OFF_DN1_XLAT     8'h98
`define BWBT_OFF_UP0_XLAT     8'ha4
`define BWBT_LUT_LOW_BIT      14
`define BWBT_LUT_SIZE_MAX     4'hf
`define BWBT_PREF_BIT         3
`define BWBT_XLAT_LOW_BIT     6
`define BWBT_RESET_WORD       32'h0000_0000
`define BWBT_XLAT_RSVD_MASK   32'hffff_ffc0

`endif

// ==== logic/bwbt_pkg.sv ====
package bwbt_pkg;

	typedef logic [31:0] bwbt_word_t;

	typedef enum logic [3:0] {
		BWBT_SEL_NONE = 4'b0001,
		BWBT_SEL_LUT  = 4'b0010,
		BWBT_SEL_DN1  = 4'b0100,
		BWBT_SEL_UP0  = 4'b1000
	} bwbt_sel_e;

endpackage : bwbt_pkg

// ==== logic/bwbt_top.sv ====
`timescale 1ns/1ps
`include "bwbt_params.svh"

module bwbt_top (
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	input  wire logic [7:0]          cfg_addr,
	input  wire logic                cfg_wr,
	input  wire logic                cfg_rd,
	input  wire logic [3:0]          cfg_be,
	input  wire bwbt_pkg::bwbt_word_t cfg_wdata,
	output bwbt_pkg::bwbt_word_t     cfg_rdata,
	output logic                     cfg_rvalid,
	input  wire logic [3:0]          window_size_sel,
	input  wire logic [31:6]         dn1_setup_mask,
	input  wire logic [31:6]         up0_setup_mask,
	input  wire logic [31:6]         dn1_bar_base,
	input  wire logic [31:6]         up0_bar_base,
	input  wire logic                dn_req_valid,
	input  wire bwbt_pkg::bwbt_word_t dn_req_addr,
	input  wire logic                up_req_valid,
	input  wire bwbt_pkg::bwbt_word_t up_req_addr,
	input  wire logic                up_page_nonpref,
	output logic                     dn_xlat_valid,
	output logic                     dn_xlat_hit,
	output bwbt_pkg::bwbt_word_t     dn_xlat_addr,
	output logic                     up_xlat_valid,
	output logic                     up_io_hit,
	output logic                     up_lut_hit,
	output logic                     up_lut_prefetch,
	output bwbt_pkg::bwbt_word_t     up_xlat_addr,
	output logic                     lut_window_en
);

	bwbt_pkg::bwbt_word_t lut_base_q;
	bwbt_pkg::bwbt_word_t dn1_xlat_q;
	bwbt_pkg::bwbt_word_t up0_xlat_q;
	bwbt_pkg::bwbt_word_t lut_mask;
	bwbt_pkg::bwbt_word_t dn1_mask;
	bwbt_pkg::bwbt_word_t up0_mask;
	bwbt_pkg::bwbt_word_t be_mask;
	bwbt_pkg::bwbt_word_t lut_read;
	bwbt_pkg::bwbt_word_t rdata_d;
	bwbt_pkg::bwbt_sel_e  sel;
	logic                 lut_en;
	logic                 dn_hit;
	logic                 up0_hit;
	logic                 lut_hit;
	logic                 up_lut_sel;
	bwbt_pkg::bwbt_word_t dn_diff;
	bwbt_pkg::bwbt_word_t up0_diff;
	bwbt_pkg::bwbt_word_t lut_diff;
	bwbt_pkg::bwbt_word_t dn_xlat_d;
	bwbt_pkg::bwbt_word_t up_xlat_d;

	assign lut_en = (window_size_sel != 4'h0);

	// Writable window bits: bit i writable when size code is nonzero and i >= 13 + size code
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_mask
			if (gi < `BWBT_LUT_LOW_BIT) begin : g_low
				assign lut_mask[gi] = 1'b0;
			end else begin : g_high
				assign lut_mask[gi] = lut_en
					&& (6'(gi) >= (6'h0d + {2'b00, window_size_sel}));
			end
			if (gi < `BWBT_XLAT_LOW_BIT) begin : g_xl
				assign dn1_mask[gi] = 1'b0;
				assign up0_mask[gi] = 1'b0;
			end else begin : g_xh
				assign dn1_mask[gi] = dn1_setup_mask[gi];
				assign up0_mask[gi] = up0_setup_mask[gi];
			end
			assign be_mask[gi] = cfg_be[gi / 8];
		end
	endgenerate

	// Address decode
	always_comb begin
		if (cfg_addr == `BWBT_OFF_LUT_BASE) begin
			sel = bwbt_pkg::BWBT_SEL_LUT;
		end else if (cfg_addr == `BWBT_OFF_DN1_XLAT) begin
			sel = bwbt_pkg::BWBT_SEL_DN1;
		end else if (cfg_addr == `BWBT_OFF_UP0_XLAT) begin
			sel = bwbt_pkg::BWBT_SEL_UP0;
		end else begin
			sel = bwbt_pkg::BWBT_SEL_NONE;
		end
	end

	// Lookup window base: bits 2:0 stay zero, bit 3 shows enable
	always_comb begin
		lut_read = lut_base_q & lut_mask;
		lut_read[2:0] = 3'b000;
		lut_read[`BWBT_PREF_BIT] = lut_en;
	end

	// Lookup window base store; bits outside the window are dropped
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lut_base_q <= `BWBT_RESET_WORD;
		end else if (cfg_wr && sel == bwbt_pkg::BWBT_SEL_LUT) begin
			lut_base_q <= ((lut_base_q & ~be_mask) | (cfg_wdata & be_mask))
				& lut_mask;
		end else begin
			lut_base_q <= lut_base_q & lut_mask;
		end
	end

	// All of bits 31:6 store and read back, used or not
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dn1_xlat_q <= `BWBT_RESET_WORD;
		end else if (cfg_wr && sel == bwbt_pkg::BWBT_SEL_DN1) begin
			dn1_xlat_q <= (dn1_xlat_q & ~be_mask)
				| (cfg_wdata & be_mask & `BWBT_XLAT_RSVD_MASK);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			up0_xlat_q <= `BWBT_RESET_WORD;
		end else if (cfg_wr && sel == bwbt_pkg::BWBT_SEL_UP0) begin
			up0_xlat_q <= (up0_xlat_q & ~be_mask)
				| (cfg_wdata & be_mask & `BWBT_XLAT_RSVD_MASK);
		end
	end

	// Read data; unmapped offsets read zero
	always_comb begin
		case (sel)
			bwbt_pkg::BWBT_SEL_LUT: rdata_d = lut_read;
			bwbt_pkg::BWBT_SEL_DN1: rdata_d = dn1_xlat_q;
			bwbt_pkg::BWBT_SEL_UP0: rdata_d = up0_xlat_q;
			default:                rdata_d = `BWBT_RESET_WORD;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cfg_rdata  <= `BWBT_RESET_WORD;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= rdata_d;
			end
		end
	end

	// Address bits that differ from each window base, inside the window mask
	always_comb begin
		dn_diff  = (dn_req_addr ^ {dn1_bar_base, 6'h00}) & dn1_mask;
		up0_diff = (up_req_addr ^ {up0_bar_base, 6'h00}) & up0_mask;
		lut_diff = (up_req_addr ^ lut_base_q) & lut_mask;
	end

	// Window hit checks on the writable base bits; an empty mask never hits
	always_comb begin
		dn_hit     = (dn1_mask != `BWBT_RESET_WORD)
			&& (dn_diff == `BWBT_RESET_WORD);
		up0_hit    = (up0_mask != `BWBT_RESET_WORD)
			&& (up0_diff == `BWBT_RESET_WORD);
		lut_hit    = lut_en && (lut_diff == `BWBT_RESET_WORD);
		up_lut_sel = lut_hit && !up0_hit;
	end

	// Next translated addresses, worked out even on a miss
	always_comb begin
		dn_xlat_d = (dn1_xlat_q & dn1_mask) | (dn_req_addr & ~dn1_mask);
		if (up_lut_sel) begin
			up_xlat_d = up_req_addr & ~lut_mask;
		end else begin
			up_xlat_d = (up0_xlat_q & up0_mask) | (up_req_addr & ~up0_mask);
		end
	end

	// Downstream direct substitution
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dn_xlat_valid <= 1'b0;
			dn_xlat_hit   <= 1'b0;
			dn_xlat_addr  <= `BWBT_RESET_WORD;
		end else begin
			dn_xlat_valid <= dn_req_valid;
			dn_xlat_hit   <= dn_req_valid && dn_hit;
			if (dn_req_valid) begin
				dn_xlat_addr <= dn_xlat_d;
			end
		end
	end

	// Upstream: direct window or table window offset
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			up_xlat_valid   <= 1'b0;
			up_io_hit       <= 1'b0;
			up_lut_hit      <= 1'b0;
			up_lut_prefetch <= 1'b0;
			up_xlat_addr    <= `BWBT_RESET_WORD;
		end else begin
			up_xlat_valid   <= up_req_valid;
			up_io_hit       <= up_req_valid && up0_hit;
			up_lut_hit      <= up_req_valid && up_lut_sel;
			up_lut_prefetch <= up_req_valid && up_lut_sel && !up_page_nonpref;
			if (up_req_valid) begin
				up_xlat_addr <= up_xlat_d;
			end
		end
	end

	// Window enable, one cycle behind the page-size setting
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lut_window_en <= 1'b0;
		end else begin
			lut_window_en <= lut_en;
		end
	end

endmodule : bwbt_top

// ==== test/bwbt_setup_model.sv ====
`timescale 1ns/1ps
module bwbt_setup_model (
	output logic [31:6] dn1_setup_mask,
	output logic [31:6] up0_setup_mask,
	output logic [31:6] dn1_bar_base,
	output logic [31:6] up0_bar_base
);
	// Setup registers as preloaded before host configuration
	assign dn1_setup_mask = 26'h3ff_ffc0;
	assign up0_setup_mask = 26'h300_0000;
	assign dn1_bar_base = 26'h300_0000;
	assign up0_bar_base = 26'h100_0000;
endmodule : bwbt_setup_model

// ==== test/bwbt_top_properties.sv ====
`timescale 1ns/1ps
module bwbt_chk (
	input wire logic                 sys_clk,
	input wire logic                 rstn,
	input wire logic                 cfg_rd,
	input wire logic                 cfg_rvalid,
	input wire logic                 lut_window_en,
	input wire logic                 up_req_valid,
	input wire logic                 dn_req_valid,
	input wire logic                 up_xlat_valid,
	input wire logic                 dn_xlat_valid,
	input wire logic                 up_lut_hit,
	input wire logic                 up_lut_prefetch,
	input wire logic                 up_page_nonpref,
	input wire logic [7:0]           cfg_addr,
	input wire logic [3:0]           window_size_sel,
	input wire bwbt_pkg::bwbt_word_t cfg_rdata
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [7:0]	a_q;
	always_ff @(posedge sys_clk) a_q <= cfg_addr;
	wire r60 = cfg_rvalid && a_q == 8'h60;
	low_bits_a: assert property (r60 |-> cfg_rdata[2:0] == 3'h0) else $error("low bits");
	rsvd_zero_a: assert property (r60 |-> cfg_rdata[13:4] == 10'h000) else $error("rsvd");
	pref_bit_a: assert property (r60 |-> cfg_rdata[3] == lut_window_en) else $error("pref");
	narrow_win_a: assert property (r60 && $past(window_size_sel) == 4'hf
		|-> cfg_rdata[27:14] == 14'h0000) else $error("narrow");
	xlat_rsvd_a: assert property (cfg_rvalid && (a_q == 8'h98 || a_q == 8'ha4)
		|-> cfg_rdata[5:0] == 6'h00) else $error("xlat rsvd");
	win_en_a: assert property ($past(rstn)
		|-> lut_window_en == ($past(window_size_sel) != 4'h0)) else $error("enable");
	reset_off_a: assert property (disable iff (1'b0) !rstn
		|=> !lut_window_en && !cfg_rvalid) else $error("reset");
	pref_mask_a: assert property (up_lut_prefetch
		|-> up_lut_hit && !$past(up_page_nonpref)) else $error("prefetch");
	up_time_a: assert property (up_req_valid |=> up_xlat_valid) else $error("up late");
	dn_time_a: assert property (dn_req_valid |=> dn_xlat_valid) else $error("dn late");
	cover property (r60 && cfg_rdata[3]);
	cover property (up_lut_prefetch);
	cover property (up_lut_hit && $past(up_page_nonpref));
	cover property (cfg_rd && cfg_addr == 8'h60 && window_size_sel == 4'hf);
endmodule : bwbt_chk
bind bwbt_top bwbt_chk chk (.sys_clk, .rstn, .cfg_rd, .cfg_rvalid, .lut_window_en, .up_req_valid,
	.dn_req_valid, .up_xlat_valid, .dn_xlat_valid, .up_lut_hit, .up_lut_prefetch,
	.up_page_nonpref, .cfg_addr, .window_size_sel, .cfg_rdata);

// ==== test/bwbt_top_tb.sv ====
`timescale 1ns/1ps
module bwbt_top_tb;
	logic	sys_clk = 0, rstn = 0, cfg_wr = 0, cfg_rd = 0, dn_req_valid = 0;
	logic	up_req_valid = 0, up_page_nonpref = 0;
	logic [7:0]	cfg_addr = 8'h00;
	logic [3:0]	window_size_sel = 4'h0;
	logic [3:0]	cfg_be = 4'hf;
	bwbt_pkg::bwbt_word_t	cfg_wdata = 0, dn_req_addr = 0, up_req_addr = 0;
	bwbt_pkg::bwbt_word_t	cfg_rdata, dn_xlat_addr, up_xlat_addr;
	logic [31:6]	dn1_setup_mask, up0_setup_mask, dn1_bar_base, up0_bar_base;
	logic	cfg_rvalid, dn_xlat_valid, dn_xlat_hit, up_xlat_valid, up_io_hit;
	logic	up_lut_hit, up_lut_prefetch, lut_window_en;
	int	n_fail = 0, n_compared = 0;
	bwbt_setup_model far (.dn1_setup_mask, .up0_setup_mask, .dn1_bar_base, .up0_bar_base);
	bwbt_top uut (.sys_clk, .rstn, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata,
		.cfg_rdata, .cfg_rvalid, .window_size_sel, .dn1_setup_mask, .up0_setup_mask,
		.dn1_bar_base, .up0_bar_base, .dn_req_valid, .dn_req_addr, .up_req_valid,
		.up_req_addr, .up_page_nonpref, .dn_xlat_valid, .dn_xlat_hit, .dn_xlat_addr,
		.up_xlat_valid, .up_io_hit, .up_lut_hit, .up_lut_prefetch, .up_xlat_addr,
		.lut_window_en);
	initial forever #25 sys_clk = ~sys_clk;
	task automatic end_sim;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask : step
	task automatic wr(logic [7:0] a, logic [31:0] d);
		step;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1;
		step;
		cfg_wr = 0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] e);
		step;
		cfg_addr = a;
		cfg_rd = 1;
		step;
		cfg_rd = 0;
		chk("rdata", cfg_rvalid ? cfg_rdata : 32'hxxxx_xxxx, e);
	endtask : rd
	task automatic ask(logic [31:0] a, logic n, logic [5:0] f, logic [31:0] ed, logic [31:0] eu);
		step;
		{dn_req_addr, up_req_addr, up_page_nonpref} = {a, a, n};
		{dn_req_valid, up_req_valid} = 2'h3;
		step;
		{dn_req_valid, up_req_valid} = 2'h0;
		chk("flags", {26'h0, dn_xlat_valid, up_xlat_valid, dn_xlat_hit, up_io_hit,
			up_lut_hit, up_lut_prefetch}, {26'h0, f});
		chk("dn_addr", dn_xlat_addr, ed);
		if (f[2:1] != 2'h0) chk("up_addr", up_xlat_addr, eu);
	endtask : ask
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		end_sim;
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 rstn = 1;
		rd(8'h60, 32'h0000_0000);
		window_size_sel = 4'h1;
		wr(8'h60, 32'hffff_ffff);
		rd(8'h60, 32'hffff_c008);
		wr(8'h60, 32'hc000_0000);
		wr(8'h98, 32'hffff_ffff);
		rd(8'h98, 32'hffff_ffc0);
		wr(8'ha4, 32'h1234_5678);
		rd(8'ha4, 32'h1234_5640);
		cfg_be = 4'h8;
		wr(8'ha4, 32'hab00_0000);
		cfg_be = 4'hf;
		rd(8'ha4, 32'hab34_5640);
		rd(8'h9c, 32'h0000_0000);
		ask(32'hc000_0abc, 1'b0, 6'h3b, 32'hffff_fabc, 32'h0000_0abc);
		ask(32'hc000_0abc, 1'b1, 6'h3a, 32'hffff_fabc, 32'h0000_0abc);
		ask(32'h4000_0abc, 1'b0, 6'h34, 32'hffff_fabc, 32'h8000_0abc);
		window_size_sel = 4'hf;
		rd(8'h60, 32'hc000_0008);
		rstn = 0;
		window_size_sel = 4'h0;
		step;
		step;
		rstn = 1;
		rd(8'h60, 32'h0000_0000);
		window_size_sel = 4'hf;
		rd(8'h60, 32'h0000_0008);
		chk("win_en", {31'h0, lut_window_en}, 32'h0000_0001);
		window_size_sel = 4'h0;
		rd(8'h60, 32'h0000_0000);
		chk("win_en", {31'h0, lut_window_en}, 32'h0000_0000);
		ask(32'hc000_0abc, 1'b0, 6'h38, 32'h0000_0abc, 32'h0000_0abc);
		end_sim;
	end
endmodule : bwbt_top_tb
